// File: sfq_frame_status.sv
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module sfq_frame_status (
    input  wire logic                           clk,         // 100 MHz channel clock
    input  wire logic                           resetn,      // async reset, active low
    input  wire logic                           psel,        // APB select
    input  wire logic                           penable,     // APB access phase
    input  wire logic                           pwrite,      // APB write
    input  wire logic [sfq_pkg::SFQ_ADDR_W-1:0] paddr,       // APB byte address
    input  wire logic [31:0]                    pwdata,      // APB write data
    output logic      [31:0]                    prdata,      // APB read data
    output logic                                pready,      // APB ready
    output logic                                pslverr,     // APB error, unmapped
    input  wire sfq_pkg::sfq_rx_s               rx,          // receiver events and status
    input  wire logic                           sdlc_mode,   // receiver in SDLC/HDLC mode
    input  wire logic                           dq_read_eof, // EOF character read at top
    input  wire logic                           dq_read_err, // error character read at top
    output logic                                dq_push,     // load byte into data queue
    output logic      [7:0]                     dq_data,     // byte to data queue
    output logic                                dq_eof,      // byte closes a frame
    output logic                                crc_reset,   // preset CRC checker
    output logic                                addr_field,  // byte is address field
    output logic                                rx_data_irq, // receive data vector pulse
    output logic                                special_irq, // special condition pulse
    output logic                                ext_irq,     // hunt/sync change pulse
    output logic                                data_lock,   // data queue locked
    output logic                                interrupt_under_service,         // interrupt under service
    output sfq_pkg::sfq_sync_e                  sync_state   // hunt or sync
);
    import sfq_pkg::*;

    // register state
    logic [7:0]           feature_control_write_reg;
    logic [7:0]           interrupt_mode_control;
    logic [SFQ_CNT_W-1:0] byte_cnt;
    logic                 in_frame;
    logic                 live_eof;
    logic                 live_crc;
    logic                 live_ovr;
    logic                 live_par;
    logic [2:0]           live_res;

    // queue wires
    sfq_entry_s q_head;
    sfq_entry_s q_din;
    logic       q_ne;
    logic       q_full;
    logic       q_ovf;
    logic       hunt_change;

    function automatic logic hit(input logic [SFQ_ADDR_W-1:0] a, input logic [7:0] off);
        hit = a == SFQ_ADDR_W'(off);
    endfunction

    // bus decode
    wire apb_acc  = psel && penable;
    wire apb_done = apb_acc && pready;
    wire hit_cmd  = hit(paddr, OFF_CMD_PSR);
    wire hit_imc  = hit(paddr, OFF_IMC_RCS);
    wire hit_bcl  = hit(paddr, OFF_BCL);
    wire hit_bch  = hit(paddr, OFF_BCH);
    wire hit_fc   = hit(paddr, OFF_FC);
    wire mapped   = hit_cmd || hit_imc || hit_bcl || hit_bch || hit_fc;
    wire wr_done  = apb_done && pwrite && mapped;
    wire rd_done  = apb_done && !pwrite;
    wire wr_cmd   = wr_done && hit_cmd;
    wire err_rst  = wr_cmd && pwdata[CMD_ERR_RST];
    wire ius_rst  = wr_cmd && pwdata[CMD_IUS_RST];
    wire hunt_cmd = wr_cmd && pwdata[CMD_HUNT];

    // queue enable and pops
    wire q_en     = feature_control_write_reg[FC_EN_BIT];
    wire q_on     = q_en && sdlc_mode;                               // see RQ6
    wire from_q   = q_on && q_ne;                                    // see RQ10
    wire rcs_pop  = rd_done && hit_imc && from_q;                    // see RQ9 RQ15

    // frame events
    wire in_sync   = sync_state == SFQ_SYNC;
    wire byte_in   = rx.byte_valid && in_sync;
    wire frame_end = rx.flag && in_frame && in_sync;
    wire abort_end = rx.abort && in_frame;
    wire any_end   = frame_end || abort_end;
    wire q_push    = any_end && q_on;                                // see RQ3 RQ5
    wire anti_lock = q_on && (interrupt_mode_control[IMC_RXI_LO+1 -: 2] == RXI_SPECIAL);

    assign q_din = '{count: byte_cnt, crc_err: rx.crc_err, overrun: live_ovr || rx.overrun,
                     residue: rx.residue};                           // see RQ12

    // read data
    wire [7:0] psr_val = {3'h0, sync_state == SFQ_HUNT, 2'h0, interrupt_under_service, data_lock};  // see RQ22
    wire [7:0] rcs_q   = {1'b1, q_head.crc_err, q_head.overrun, live_par,
                          q_head.residue, rx.all_sent};              // see RQ12 RQ13
    wire [7:0] rcs_lv  = {live_eof, live_crc, live_ovr, live_par, live_res, rx.all_sent};
    wire [7:0] rcs_val = from_q ? rcs_q : rcs_lv;                    // see RQ9 RQ10
    // an empty queue has no valid head; counts read zero rather than stale memory
    wire [7:0] bcl_val = from_q ? q_head.count[7:0] : 8'h00;         // see RQ2 RQ10
    wire [5:0] bch_cnt = from_q ? q_head.count[SFQ_CNT_W-1:8] : 6'h00;  // see RQ10
    wire [7:0] bch_val = q_on ? {q_ovf, q_ne, bch_cnt} : 8'h00;      // see RQ11 RQ17
    wire [7:0] fc_val  = {5'h00, q_en, 2'h0};                        // see RQ8
    wire [7:0] rd_sel  = hit_cmd ? psr_val :
                         hit_imc ? rcs_val :
                         hit_bcl ? bcl_val :
                         hit_bch ? bch_val :
                         hit_fc  ? fc_val  : 8'h00;

    sfq_status_queue #(
        .DEPTH     (SFQ_DEPTH),
        .WIDTH     (SFQ_ENT_W)
    ) u_queue (
        .clk       (clk),
        .resetn    (resetn),
        .clear     (!q_on),                                          // see RQ7 RQ17
        .push      (q_push),
        .din       (q_din),
        .pop       (rcs_pop),
        .dout      (q_head),
        .not_empty (q_ne),
        .full      (q_full),
        .overflow  (q_ovf)
    );

    sfq_hunt u_hunt (
        .clk        (clk),
        .resetn     (resetn),
        .flag       (rx.flag),
        .abort      (rx.abort),
        .byte_valid (rx.byte_valid),
        .enter_hunt (hunt_cmd),
        .state      (sync_state),
        .change     (hunt_change),
        .addr_byte  (addr_field)
    );

    // APB slave: one wait cycle, data and ready registered together
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_acc && !pready;
            pslverr <= apb_acc && !pready && !mapped;
            if (apb_acc && !pready && !pwrite) prdata <= {24'h000000, rd_sel};  // see RQ16
        end
    end

    // control registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            feature_control_write_reg <= RST_FC;                     // see RQ7
            interrupt_mode_control    <= RST_IMC;
        end else begin
            if (wr_done && hit_fc) feature_control_write_reg <= pwdata[7:0];
            if (wr_done && hit_imc) interrupt_mode_control <= pwdata[7:0];
        end
    end

    // byte counter and frame tracking
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            byte_cnt <= '0;
            in_frame <= 1'b0;
        end else if (any_end || !in_sync) begin
            byte_cnt <= '0;                                          // see RQ5 RQ24
            in_frame <= 1'b0;
        end else if (byte_in) begin
            byte_cnt <= byte_cnt + 1'b1;                             // see RQ24
            in_frame <= 1'b1;
        end
    end

    // live status; hardware set wins over error reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            live_eof <= 1'b0;
            live_crc <= 1'b0;
            live_ovr <= 1'b0;
            live_par <= 1'b0;
            live_res <= 3'h0;
        end else begin
            live_eof <= frame_end || (live_eof && !err_rst);         // see RQ23
            live_ovr <= rx.overrun || (live_ovr && !err_rst);
            live_par <= rx.parity_err || (live_par && !err_rst);
            if (frame_end) begin
                live_crc <= rx.crc_err;                              // see RQ23
                live_res <= rx.residue;
            end
        end
    end

    // data path and receive interrupts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dq_push     <= 1'b0;
            dq_data     <= 8'h00;
            dq_eof      <= 1'b0;
            crc_reset   <= 1'b0;
            rx_data_irq <= 1'b0;
            special_irq <= 1'b0;
            ext_irq     <= 1'b0;
            data_lock   <= 1'b0;
            interrupt_under_service         <= 1'b0;
        end else begin
            dq_push     <= byte_in || frame_end;                     // see RQ23
            dq_data     <= rx.data;
            dq_eof      <= frame_end;
            crc_reset   <= any_end;                                  // see RQ4
            rx_data_irq <= dq_read_eof && anti_lock;                 // see RQ18
            special_irq <= dq_read_err || (dq_read_eof && !anti_lock);  // see RQ20
            ext_irq     <= hunt_change;                              // see RQ22
            data_lock   <= dq_read_err || (dq_read_eof && !anti_lock)
                           || (data_lock && !err_rst);               // see RQ18 RQ20
            interrupt_under_service         <= dq_read_eof || dq_read_err || hunt_change
                           || (interrupt_under_service && !ius_rst);
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_frame_store;
        q_on && any_end && !q_full;
    endsequence

    sequence s_empty_pop;
        rd_done && hit_imc && !q_ne && !q_push;
    endsequence

    a_push_on_end: assert property (s_frame_store |=> q_ne)  // see RQ3
        else $error("frame end did not store an entry");
    a_crc_after_store: assert property (any_end |=> crc_reset ##1 !crc_reset)  // see RQ4
        else $error("checker reset not a single pulse after frame end");
    a_count_restart: assert property (any_end |=> byte_cnt == '0)  // see RQ5
        else $error("byte counter did not restart");
    a_disable_clears: assert property (!q_on |=> !q_ne && !q_ovf)  // see RQ7
        else $error("queue state survived disable");
    a_readback_en: assert property (apb_acc && !pready && !pwrite && hit_fc
                                    |=> prdata[FC_EN_BIT] == $past(q_en))  // see RQ8
        else $error("enable readback wrong");
    a_eof_from_q: assert property (apb_acc && !pready && !pwrite && hit_imc && from_q
                                   |=> prdata[7])  // see RQ13
        else $error("queued status without end-of-frame bit");
    a_avail_bit: assert property (apb_acc && !pready && !pwrite && hit_bch && q_on
                                  |=> prdata[BCH_AVAIL] == $past(q_ne))  // see RQ11
        else $error("not-empty bit wrong");
    a_no_underflow: assert property (s_empty_pop |=> !q_ne)  // see RQ15
        else $error("pop on empty queue changed state");
    a_ovf_sticky: assert property (q_ovf && q_on |=> q_ovf)  // see RQ17
        else $error("overflow flag cleared while enabled");
    a_anti_lock: assert property (anti_lock && dq_read_eof && !dq_read_err && !data_lock
                                  |=> rx_data_irq && !special_irq && !data_lock)  // see RQ18
        else $error("anti-lock EOF read misbehaved");
    a_err_lock: assert property (dq_read_err |=> special_irq && data_lock)  // see RQ20
        else $error("error character did not lock");
    a_hunt_irq: assert property ($changed(sync_state) |=> ext_irq)  // see RQ22
        else $error("hunt/sync change without interrupt");
endmodule

// File: sfq_hunt.sv
`timescale 1ns/10ps
module sfq_hunt (
    input  wire logic               clk,        // channel clock
    input  wire logic               resetn,     // async reset, active low
    input  wire logic               flag,       // flag pattern matched
    input  wire logic               abort,      // seven ones seen
    input  wire logic               byte_valid, // non-flag byte assembled
    input  wire logic               enter_hunt, // software hunt command
    output sfq_pkg::sfq_sync_e      state,      // hunt or sync
    output logic                    change,     // pulse on state change
    output logic                    addr_byte   // pulse: byte is address field
);
    import sfq_pkg::*;
    sfq_sync_e next_state;
    logic      want_addr;

    always_comb begin
        next_state = state;
        unique case (state)
            SFQ_HUNT: if (flag) next_state = SFQ_SYNC;              // see RQ21
            SFQ_SYNC: if (abort || enter_hunt) next_state = SFQ_HUNT;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state     <= SFQ_HUNT;
            change    <= 1'b0;
            addr_byte <= 1'b0;
            want_addr <= 1'b0;
        end else begin
            state     <= next_state;
            change    <= next_state != state;                       // see RQ22
            addr_byte <= (state == SFQ_SYNC) && want_addr && byte_valid;
            if (state == SFQ_HUNT && flag) want_addr <= 1'b1;       // see RQ21
            else if (byte_valid || next_state == SFQ_HUNT) want_addr <= 1'b0;
        end
    end
endmodule

// File: sfq_pkg.sv
// Overview of operation
// RQ1: ten by nineteen status queue, separate
// RQ2: byte count registers readable only when enabled
// RQ3: end of frame pushes count and status
// RQ4: checker reset after storing frame status
// RQ5: abort also stores count, then restarts
// RQ6: queue active only enabled and SDLC mode
// RQ7: disable or reset clears pointers; enable 0
// RQ8: readback bit 2 shows enable state
// RQ9: status and count reads from queue; pop
// RQ10: empty queue: status from live register
// RQ11: high count bit 6 means not empty
// RQ12: residue, overrun, CRC pass; others bypass
// RQ13: end-of-frame bit reads 1 from queue
// RQ14: software reads high, low, then status
// RQ15: pops on empty queue are blocked
// RQ16: high count read captures not-empty bit
// RQ17: overflow flag bit 7, cleared by re-enable
// RQ18: anti-lock: EOF read gives data interrupt
// RQ19: software resets in-service flag each routine
// RQ20: other special conditions interrupt and lock
// RQ21: hunt seeks flag; then address byte
// RQ22: hunt/sync status and change interrupt
// RQ23: closing flag loads data, latches status
// RQ24: byte counter counts bytes, restarts per frame
package sfq_pkg;
    localparam int          SFQ_DEPTH     = 10;
    localparam int          SFQ_CNT_W     = 14;
    localparam int          SFQ_ENT_W     = 19;
    localparam int          SFQ_ADDR_W    = 8;
    localparam logic [7:0]  OFF_CMD_PSR   = 8'h00;
    localparam logic [7:0]  OFF_IMC_RCS   = 8'h04;
    localparam logic [7:0]  OFF_BCL       = 8'h18;
    localparam logic [7:0]  OFF_BCH       = 8'h1C;
    localparam logic [7:0]  OFF_FC        = 8'h3C;
    localparam int          FC_EN_BIT     = 2;
    localparam int          IMC_RXI_LO    = 3;
    localparam logic [1:0]  RXI_SPECIAL   = 2'h3;
    localparam int          CMD_ERR_RST   = 0;
    localparam int          CMD_IUS_RST   = 1;
    localparam int          CMD_HUNT      = 2;
    localparam int          PSR_LOCK      = 0;
    localparam int          PSR_IUS       = 1;
    localparam int          PSR_HUNT      = 4;
    localparam int          BCH_OVF       = 7;
    localparam int          BCH_AVAIL     = 6;
    localparam logic [7:0]  RST_FC        = 8'h00;
    localparam logic [7:0]  RST_IMC       = 8'h00;

    typedef struct packed {
        logic [SFQ_CNT_W-1:0] count;
        logic                 crc_err;
        logic                 overrun;
        logic [2:0]           residue;
    } sfq_entry_s;

    typedef struct packed {
        logic       byte_valid;
        logic [7:0] data;
        logic       flag;
        logic       abort;
        logic       crc_err;
        logic       overrun;
        logic       parity_err;
        logic [2:0] residue;
        logic       all_sent;
    } sfq_rx_s;

    typedef enum logic [0:0] {
        SFQ_HUNT = 1'b0,
        SFQ_SYNC = 1'b1
    } sfq_sync_e;
endpackage

// File: sfq_rx_src.sv
`timescale 1ns/10ps
module sfq_rx_src (
    input  wire logic       clk, // channel clock
    output sfq_pkg::sfq_rx_s rx  // receiver events toward the block
);
    import sfq_pkg::*;

    initial begin
        rx = '0;
    end

    // opening flag, n bytes, then closing flag or abort
    task automatic frame(input int n, input logic crc, input logic [2:0] res, input logic abrt);
        int i;
        @(posedge clk);
        rx.flag <= 1'b1;
        @(posedge clk);
        rx.flag <= 1'b0;
        repeat (3) @(posedge clk);
        for (i = 0; i < n; i++) begin
            rx.byte_valid <= 1'b1;
            rx.data       <= 8'($urandom);
            @(posedge clk);
            rx.byte_valid <= 1'b0;
            // idle data never repeats the last byte
            rx.data       <= ~rx.data;
            @(posedge clk);
        end
        rx.crc_err <= crc;
        rx.residue <= res;
        if (abrt) begin
            rx.abort <= 1'b1;
        end else begin
            rx.flag <= 1'b1;
        end
        @(posedge clk);
        rx.abort <= 1'b0;
        rx.flag  <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

// File: sfq_status_queue.sv
`timescale 1ns/10ps
module sfq_status_queue #(
    parameter int DEPTH = sfq_pkg::SFQ_DEPTH,
    parameter int WIDTH = sfq_pkg::SFQ_ENT_W
) (
    input  wire logic             clk,       // channel clock
    input  wire logic             resetn,    // async reset, active low
    input  wire logic             clear,     // synchronous pointer clear
    input  wire logic             push,      // store one entry
    input  wire logic [WIDTH-1:0] din,       // entry to store
    input  wire logic             pop,       // drop head entry
    output logic      [WIDTH-1:0] dout,      // head entry
    output logic                  not_empty, // at least one entry
    output logic                  full,      // all entries used
    output logic                  overflow   // push met a full queue
);
    import sfq_pkg::*;
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULLC = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];                    // see RQ1
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    fill;
    wire              do_push = push && !full;
    wire              do_pop  = pop && not_empty;     // see RQ15

    assign dout      = mem[rd_ptr];
    assign not_empty = fill != '0;
    assign full      = fill == FULLC;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= din;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            fill     <= '0;
            overflow <= 1'b0;
        end else if (clear) begin                     // see RQ7
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            fill     <= '0;
            overflow <= 1'b0;
        end else begin
            if (do_push) wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;   // see RQ3
            if (do_pop) rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            fill <= fill + CW'(do_push) - CW'(do_pop);
            if (push && full) overflow <= 1'b1;       // see RQ17
        end
    end
endmodule

// File: tb.sv
`timescale 1ns/10ps
module tb;
    import sfq_pkg::*;
    logic        clk, resetn, psel, penable, pwrite, sdlc_mode, dq_eof_rd, dq_err_rd;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, crc_reset;
    logic        dq_push, dq_eof, addr_field, rx_irq, sp_irq, ext_irq, data_lock;
    logic [7:0]  dq_data;
    int          n_ext, n_addr, n_eof;
    sfq_sync_e   sync_state;
    sfq_rx_s     rx;
    logic [33:0] q[$];
    logic [33:0] note;
    int          fails, n_tests, n_crc, cyc, n, k;
    logic        crc;
    logic [2:0]  res;

    sfq_rx_src src (.clk(clk), .rx(rx));
    sfq_frame_status uut (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx(rx), .sdlc_mode(sdlc_mode), .dq_read_eof(dq_eof_rd), .dq_read_err(dq_err_rd),
        .dq_push(dq_push), .dq_data(dq_data), .dq_eof(dq_eof), .crc_reset(crc_reset),
        .addr_field(addr_field), .rx_data_irq(rx_irq), .special_irq(sp_irq),
        .ext_irq(ext_irq), .data_lock(data_lock), .interrupt_under_service(),
        .sync_state(sync_state));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("tests %0d errors %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // one-cycle read pulse at the data queue top; returns at the following falling edge
    task automatic pulse(input logic err);
        @(posedge clk);
        dq_eof_rd <= !err;
        dq_err_rd <= err;
        @(posedge clk);
        dq_eof_rd <= 1'b0;
        dq_err_rd <= 1'b0;
        @(negedge clk);
    endtask

    // the note holds {check, pslverr, prdata}
    task automatic rd(input logic [7:0] a, input logic c, input logic [32:0] e);
        q.push_back({c, e});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic entry(input int cnt, input logic c, input logic [2:0] r, input logic st);
        rd(OFF_BCH, 1'b1, {25'h0, 2'b01, 6'(cnt >> 8)});
        rd(OFF_BCL, 1'b1, {25'h0, 8'(cnt)});
        rd(OFF_IMC_RCS, st, {25'h0, 1'b1, c, 2'b00, r, 1'b0});
    endtask

    always @(negedge clk) begin
        if (psel && penable && pready && !pwrite && q.size() > 0) begin
            note = q.pop_front();
            if (note[33]) begin
                check({pslverr, prdata}, note[32:0]);
            end
        end
        if (crc_reset && sdlc_mode) begin
            n_crc++;
        end
        n_ext  += ext_irq;
        n_addr += addr_field;
        n_eof  += dq_push && dq_eof;
        if (dq_push && !dq_eof) begin
            check(33'(dq_data ^ rx.data), 33'hFF);
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc >= 20000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
        sdlc_mode = 1; dq_eof_rd = 0; dq_err_rd = 0;
        void'($urandom(32'hef6a));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(OFF_FC, 1'b1, 33'h0);
        rd(OFF_CMD_PSR, 1'b1, 33'h10);
        rd(8'h40, 1'b1, {1'b1, 32'h0});
        src.frame(3, 1'b0, 3'h0, 1'b0);
        rd(OFF_BCH, 1'b1, 33'h0);
        apb(1'b1, OFF_FC, 32'h4);
        rd(OFF_FC, 1'b1, 33'h4);
        for (k = 0; k < 2; k++) begin
            n = 1 + $urandom % 20;
            crc = 1'($urandom);
            res = 3'($urandom);
            src.frame(n, crc, res, 1'b0);
            entry(n, crc, res, 1'b1);
        end
        rd(OFF_BCH, 1'b1, 33'h0);
        rd(OFF_IMC_RCS, 1'b1, {25'h0, 1'b1, crc, 2'b00, res, 1'b0});
        rd(OFF_IMC_RCS, 1'b1, {25'h0, 1'b1, crc, 2'b00, res, 1'b0});
        src.frame(5, 1'b1, 3'h5, 1'b0);
        entry(5, 1'b1, 3'h5, 1'b1);
        src.frame(7, 1'b0, 3'h2, 1'b1);
        check(33'(sync_state), 33'(SFQ_HUNT));
        src.frame(4, 1'b0, 3'h3, 1'b0);
        entry(7, 1'b0, 3'h2, 1'b1);
        entry(4, 1'b0, 3'h3, 1'b1);
        for (k = 0; k < 11; k++) begin
            src.frame(k + 1, 1'b0, 3'h1, 1'b0);
        end
        rd(OFF_BCH, 1'b1, 33'hC0);
        rd(OFF_BCL, 1'b1, 33'h1);
        apb(1'b1, OFF_FC, 32'h0);
        rd(OFF_FC, 1'b1, 33'h0);
        apb(1'b1, OFF_FC, 32'h4);
        rd(OFF_BCH, 1'b1, 33'h0);
        sdlc_mode <= 1'b0;
        src.frame(2, 1'b0, 3'h0, 1'b0);
        sdlc_mode <= 1'b1;
        rd(OFF_BCH, 1'b1, 33'h0);
        apb(1'b1, OFF_IMC_RCS, 32'h18);
        pulse(1'b0);
        check({30'h0, rx_irq, sp_irq, data_lock}, 33'h4);
        rd(OFF_CMD_PSR, 1'b1, 33'h2);
        apb(1'b1, OFF_CMD_PSR, 32'h2);
        rd(OFF_CMD_PSR, 1'b1, 33'h0);
        pulse(1'b1);
        check({30'h0, rx_irq, sp_irq, data_lock}, 33'h3);
        rd(OFF_CMD_PSR, 1'b1, 33'h3);
        apb(1'b1, OFF_CMD_PSR, 32'h3);
        rd(OFF_CMD_PSR, 1'b1, 33'h0);
        check(33'(n_crc), 33'd17);
        check(33'(n_ext), 33'd3);
        check(33'(n_addr), 33'd2);
        check(33'(n_eof), 33'd17);
        stop_test();
    end
endmodule
